// >>> rtl/igx_expander.sv
// Eight-bit port expander behind a serial two-wire slave
`timescale 1ns/1ps
module igx_expander (
	input  wire logic                         i_ref_clk,
	input  wire logic                         i_rst_b,
	input  wire logic                         i_scl,
	input  wire logic                         i_sda,
	output logic                              o_sda,
	output logic                              o_sda_oe_b,
	input  wire logic                         i_addr_sel,
	input  wire logic [igx_pkg::PORT_W-1:0]   i_port_pin,
	output logic      [igx_pkg::PORT_W-1:0]   o_port_pin,
	output logic      [igx_pkg::PORT_W-1:0]   o_port_oe_b,
	output logic      [igx_pkg::PORT_W-1:0]   o_pull_enable,
	output logic      [igx_pkg::PORT_W-1:0]   o_pull_up,
	output logic      [2*igx_pkg::PORT_W-1:0] o_drive_strength,
	output logic                              o_int,
	output logic                              o_int_oe_b
);
	import igx_pkg::*;

	logic [1:0]        addr_sync;
	logic [PORT_W-1:0] pin_s1;
	logic [PORT_W-1:0] pin_lvl;
	logic              scl_f;
	logic              sda_f;
	logic              scl_q;
	logic              sda_q;
	igx_state_e        state;
	igx_kind_e         kind;
	logic [7:0]        shreg;
	logic [3:0]        bit_cnt;
	logic              rw;
	logic              sda_drv;
	logic [7:0]        ptr;
	logic [7:0]        pin_output_levels;
	logic [7:0]        input_polarity_invert;
	logic [7:0]        pin_direction;
	logic [7:0]        drive_strength_low;
	logic [7:0]        drive_strength_high;
	logic [7:0]        input_capture_hold;
	logic [7:0]        pull_resistor_enable;
	logic [7:0]        pull_direction_select;
	logic [7:0]        interrupt_mask;
	logic [7:0]        output_structure_control;
	logic [7:0]        held;
	logic [7:0]        cap;
	logic [7:0]        pend;
	logic              int_q;

	// Command code maps onto an implemented register
	function automatic logic is_mapped(input logic [7:0] code);
		is_mapped = (code <= REG_DIR) || ((code >= REG_DS_LO) && (code <= REG_SOURCE)) || (code == REG_OSTRUC);
	endfunction

	// Command code names a register software may write
	function automatic logic is_writable(input logic [7:0] code);
		is_writable = is_mapped(code) && (code != REG_INPUT) && (code != REG_SOURCE);
	endfunction

	// Pin and address-select synchronisers
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			addr_sync <= '0;
			pin_s1    <= '0;
			pin_lvl   <= '0;
		end else begin
			addr_sync <= {addr_sync[0], i_addr_sel};
			pin_s1    <= i_port_pin;
			pin_lvl   <= pin_s1;
		end
	end

	igx_glitch_filter u_scl_filt (
		.i_ref_clk (i_ref_clk),
		.i_rst_b   (i_rst_b),
		.i_line    (i_scl),
		.o_level   (scl_f)
	);
	igx_glitch_filter u_sda_filt (
		.i_ref_clk (i_ref_clk),
		.i_rst_b   (i_rst_b),
		.i_line    (i_sda),
		.o_level   (sda_f)
	);

	// Previous filtered levels for edge detection
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_f;
			sda_q <= sda_f;
		end
	end

	// bus events, oversampled above fast-mode rate
	wire scl_rise  = scl_f & ~scl_q;
	wire scl_fall  = ~scl_f & scl_q;
	wire bus_start = scl_f & scl_q & sda_q & ~sda_f;
	wire bus_stop  = scl_f & scl_q & ~sda_q & sda_f;
	wire addr_hit  = (shreg[7:1] == {ADDR_FIXED, addr_sync[1]});
	wire byte_done = (state == ST_RX) && scl_fall && (bit_cnt == BITS_BYTE);
	wire cmd_wr    = byte_done && (kind == KIND_CMD);
	wire data_wr   = byte_done && (kind == KIND_DATA);
	wire load_tx   = scl_fall && (((state == ST_ACK) && rw) || (state == ST_RACK));
	wire in_rd     = load_tx && (ptr == REG_INPUT);

	// Input view, interrupt sources
	wire [7:0] pin_diff = (pin_lvl ^ held) & pin_direction;
	wire [7:0] in_raw   = (pend & cap) | (~pend & pin_lvl);
	wire [7:0] in_value = in_raw ^ input_polarity_invert;
	wire [7:0] set_vec  = pin_diff & input_capture_hold & ~pend & ~{8{in_rd}};
	wire [7:0] int_raw  = (input_capture_hold & pend) | (~input_capture_hold & pin_diff);
	wire [7:0] int_src  = int_raw & ~interrupt_mask;
	wire       od_sel   = output_structure_control[OD_BIT];

	wire [7:0] rd_data =
		(ptr == REG_INPUT)  ? in_value :
		(ptr == REG_OUTPUT) ? pin_output_levels :
		(ptr == REG_INVERT) ? input_polarity_invert :
		(ptr == REG_DIR)    ? pin_direction :
		(ptr == REG_DS_LO)  ? drive_strength_low :
		(ptr == REG_DS_HI)  ? drive_strength_high :
		(ptr == REG_HOLD)   ? input_capture_hold :
		(ptr == REG_PULLEN) ? pull_resistor_enable :
		(ptr == REG_PULLUP) ? pull_direction_select :
		(ptr == REG_MASK)   ? interrupt_mask :
		(ptr == REG_SOURCE) ? int_src :
		(ptr == REG_OSTRUC) ? output_structure_control : RST_ZEROS;

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state   <= ST_IDLE;
			kind    <= KIND_ADDR;
			shreg   <= '0;
			bit_cnt <= '0;
			rw      <= 1'b0;
			sda_drv <= 1'b0;
			ptr     <= REG_INPUT;
		end else if (bus_start) begin
			state   <= ST_RX;
			kind    <= KIND_ADDR;
			bit_cnt <= '0;
			sda_drv <= 1'b0;
		end else if (bus_stop) begin
			state   <= ST_IDLE;
			sda_drv <= 1'b0;
		end else begin
			unique case (state)
				ST_IDLE: begin
					sda_drv <= 1'b0;
				end
				ST_RX: begin
					if (scl_rise && (bit_cnt != BITS_BYTE)) begin
						shreg   <= {shreg[6:0], sda_f};
						bit_cnt <= bit_cnt + 4'h1;
					end else if (byte_done) begin
						bit_cnt <= '0;
						if (kind == KIND_ADDR) begin
							state   <= addr_hit ? ST_ACK : ST_IDLE;
							sda_drv <= addr_hit;
							rw      <= shreg[RW_BIT];
							kind    <= KIND_CMD;
						end else begin
							state   <= ST_ACK;
							sda_drv <= 1'b1;
							kind    <= KIND_DATA;
						end
						if (kind == KIND_CMD) begin
							ptr <= shreg;
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						bit_cnt <= '0;
						if (rw) begin
							state   <= ST_TX;
							shreg   <= rd_data;
							sda_drv <= ~rd_data[7];
						end else begin
							state   <= ST_RX;
							sda_drv <= 1'b0;
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (bit_cnt == LAST_TX) begin
							state   <= ST_RACK;
							sda_drv <= 1'b0;
						end else begin
							shreg   <= {shreg[6:0], 1'b0};
							sda_drv <= ~shreg[6];
							bit_cnt <= bit_cnt + 4'h1;
						end
					end
				end
				ST_RACK: begin
					if (scl_rise && sda_f) begin
						state <= ST_IDLE;
					end else if (scl_fall) begin
						state   <= ST_TX;
						bit_cnt <= '0;
						shreg   <= rd_data;
						sda_drv <= ~rd_data[7];
					end
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pin_output_levels        <= RST_ONES;
			input_polarity_invert    <= RST_ZEROS;
			pin_direction            <= RST_ONES;
			drive_strength_low       <= RST_ONES;
			drive_strength_high      <= RST_ONES;
			input_capture_hold       <= RST_ZEROS;
			pull_resistor_enable     <= RST_ZEROS;
			pull_direction_select    <= RST_ONES;
			interrupt_mask           <= RST_ONES;
			output_structure_control <= RST_ZEROS;
		end else if (data_wr && is_writable(ptr)) begin
			unique case (ptr)
				REG_OUTPUT: pin_output_levels <= shreg;
				REG_INVERT: input_polarity_invert <= shreg;
				REG_DIR:    pin_direction <= shreg;
				REG_DS_LO:  drive_strength_low <= shreg;
				REG_DS_HI:  drive_strength_high <= shreg;
				REG_HOLD:   input_capture_hold <= shreg;
				REG_PULLEN: pull_resistor_enable <= shreg;
				REG_PULLUP: pull_direction_select <= shreg;
				REG_MASK:   interrupt_mask <= shreg;
				REG_OSTRUC: output_structure_control <= shreg;
				default:    pin_output_levels <= pin_output_levels;
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			held <= '0;
			cap  <= '0;
			pend <= '0;
		end else begin
			if (in_rd) begin
				held <= pin_lvl;
			end
			cap  <= (cap & ~set_vec) | (pin_lvl & set_vec);
			pend <= (pend & input_capture_hold & ~{8{in_rd}}) | set_vec;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			int_q <= 1'b0;
		end else begin
			int_q <= |int_src;
		end
	end

	assign o_int      = 1'b0;
	assign o_int_oe_b = ~int_q;
	assign o_sda      = 1'b0;
	assign o_sda_oe_b = ~sda_drv;

	assign o_port_pin  = pin_output_levels;
	assign o_port_oe_b = pin_direction | ({8{od_sel}} & pin_output_levels);
	assign o_pull_enable    = pull_resistor_enable & ~(~pin_direction & {8{od_sel}});
	assign o_pull_up        = pull_direction_select;
	assign o_drive_strength = {drive_strength_high, drive_strength_low};

	pin_dir_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		&(o_port_oe_b | ~pin_direction))
		else $error("input pin is being driven");

	od_high_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		od_sel |-> &(o_port_oe_b | ~pin_output_levels))
		else $error("open-drain pin drives high");

	mask_status_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		(&interrupt_mask) |-> (int_src == 8'h00) ##1 o_int_oe_b)
		else $error("masked bit shows as source");

	int_pin_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		(!in_rd && (pin_diff & ~interrupt_mask) != 8'h00) |-> ##[1:2] !o_int_oe_b)
		else $error("interrupt not driven low");

	ptr_hold_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		$changed(ptr) |-> $past(cmd_wr))
		else $error("pointer changed without command byte");

	latch_keep_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		(!in_rd && (pend & input_capture_hold) != 8'h00) |=> ((pend & $past(pend & input_capture_hold))
		== $past(pend & input_capture_hold)))
		else $error("latched capture lost before read");

	ro_write_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		(data_wr && !is_writable(ptr)) |=> $stable(pin_output_levels) && $stable(pin_direction))
		else $error("write to read-only code changed state");

	addr_ack_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		(byte_done && kind == KIND_ADDR && !addr_hit) |=> state == ST_IDLE && !sda_drv)
		else $error("foreign address acknowledged");

	invert_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		(pend == 8'h00) |-> in_value == (pin_lvl ^ input_polarity_invert))
		else $error("input view ignores inversion");
endmodule

// >>> rtl/igx_pkg.sv
// Shared constants for the serial-bus eight-bit port expander
package igx_pkg;
	localparam int PORT_W   = 8;
	// Core clock and serial-bus timing
	localparam int CLK_MHZ  = 20;
	localparam int BUS_KHZ  = 400;
	localparam int FILT_NS  = 50;
	localparam int FILT_CYC = (FILT_NS * CLK_MHZ + 999) / 1000;
	localparam int OVERSAMP = (CLK_MHZ * 1000) / BUS_KHZ;
	localparam logic [1:0] FILT_MAX = 2'(FILT_CYC);
	// Slave address, upper six bits fixed
	localparam logic [5:0] ADDR_FIXED = 6'h10;
	// Register command codes
	localparam logic [7:0] REG_INPUT  = 8'h00;
	localparam logic [7:0] REG_OUTPUT = 8'h01;
	localparam logic [7:0] REG_INVERT = 8'h02;
	localparam logic [7:0] REG_DIR    = 8'h03;
	localparam logic [7:0] REG_DS_LO  = 8'h40;
	localparam logic [7:0] REG_DS_HI  = 8'h41;
	localparam logic [7:0] REG_HOLD   = 8'h42;
	localparam logic [7:0] REG_PULLEN = 8'h43;
	localparam logic [7:0] REG_PULLUP = 8'h44;
	localparam logic [7:0] REG_MASK   = 8'h45;
	localparam logic [7:0] REG_SOURCE = 8'h46;
	localparam logic [7:0] REG_OSTRUC = 8'h4f;
	// Reset values, bit positions and bit counts
	localparam logic [7:0] RST_ONES  = 8'hff;
	localparam logic [7:0] RST_ZEROS = 8'h00;
	localparam int OD_BIT  = 0;
	localparam int RW_BIT  = 0;
	localparam logic [3:0] BITS_BYTE = 4'h8;
	localparam logic [3:0] LAST_TX   = 4'h7;
	// Bus engine states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RX   = 3'b001,
		ST_ACK  = 3'b010,
		ST_TX   = 3'b011,
		ST_RACK = 3'b100
	} igx_state_e;
	// Meaning of the byte being received
	typedef enum logic [1:0] {
		KIND_ADDR = 2'b00,
		KIND_CMD  = 2'b01,
		KIND_DATA = 2'b10
	} igx_kind_e;
endpackage

// >>> rtl/igx_glitch_filter.sv
// Synchroniser and spike filter for one serial-bus line
`timescale 1ns/1ps
module igx_glitch_filter (
	input  wire logic i_ref_clk,
	input  wire logic i_rst_b,
	input  wire logic i_line,
	output logic      o_level
);
	import igx_pkg::*;

	logic       sync1;
	logic       sync2;
	logic [1:0] stable_cnt;

	// Two-stage synchroniser, idle bus is high
	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sync1 <= 1'b1;
			sync2 <= 1'b1;
		end else begin
			sync1 <= i_line;
			sync2 <= sync1;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_level    <= 1'b1;
			stable_cnt <= '0;
		end else if (sync2 == o_level) begin
			stable_cnt <= '0;
		end else if (stable_cnt == FILT_MAX) begin
			o_level    <= sync2;
			stable_cnt <= '0;
		end else begin
			stable_cnt <= stable_cnt + 2'h1;
		end
	end

	filt_stable_a: assert property (
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		$changed(o_level) |-> $past(sync2, 1) == $past(sync2, 2))
		else $error("filter passed a single-sample spike");
endmodule

// >>> sim/igx_host_model.sv
// Behavioural serial-bus host that drives clock and data
`timescale 1ns/1ps
module igx_host_model (
	output logic      o_scl,
	output logic      o_sda,
	input  wire logic i_sda
);
	// Quarter of a bit time; the bench may stretch it for a slow host
	int q = 207;
	// Lines released while idle
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	task automatic bit_io(input logic b, output logic r);
		o_sda = b;
		#(q);
		o_scl = 1'b1;
		r = i_sda;
		#(2 * q);
		o_scl = 1'b0;
		#(q);
	endtask
	task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] r, output logic k);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r[i]);
		end
		bit_io(a, k);
	endtask
	// Start or repeated start, data falls while clock is high
	task automatic start();
		o_sda = 1'b1;
		#(q);
		o_scl = 1'b1;
		#(q);
		o_sda = 1'b0;
		#(q);
		o_scl = 1'b0;
		#(q);
	endtask
	// Stop, data rises while clock is high, then both released
	task automatic stop();
		o_sda = 1'b0;
		#(q);
		o_scl = 1'b1;
		#(q);
		o_sda = 1'b1;
		#(2 * q);
	endtask
endmodule

// >>> sim/igx_expander_tb_top.sv
// Self-checking bench for the serial-bus port expander
`timescale 1ns/1ps
module igx_expander_tb_top;
	import igx_pkg::*;
	localparam logic [7:0] CODE [12] = '{REG_INPUT, REG_OUTPUT, REG_INVERT, REG_DIR, REG_DS_LO, REG_DS_HI,
		REG_HOLD, REG_PULLEN, REG_PULLUP, REG_MASK, REG_SOURCE, REG_OSTRUC};
	localparam logic [7:0] DFLT [12] = '{8'h00, 8'hff, 8'h00, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff,
		8'hff, 8'h00, 8'h00};
	logic        i_ref_clk  = 1'b0;
	logic        i_rst_b    = 1'b0;
	logic        i_addr_sel = 1'b0;
	logic [7:0]  i_port_pin = 8'h00;
	wire         scl;
	wire         sda_h;
	wire         sda_oe_b;
	wire         int_oe_b;
	wire         int_lo;
	wire         sda_lo;
	// Open-drain lines with pull-ups, low when the host drives low or a device output is enabled and driven low
	wire         sda        = sda_h & (sda_oe_b | sda_lo);
	wire         int_line_b = int_oe_b | int_lo;
	logic [7:0]  o_port_pin;
	logic [7:0]  o_port_oe_b;
	logic [7:0]  o_pull_enable;
	logic [7:0]  o_pull_up;
	logic [15:0] o_drive_strength;
	logic [15:0] lfsr       = 16'h3046;
	logic [7:0]  v [12];
	logic [7:0]  rv;
	logic [7:0]  p;
	logic        ack;
	int          num_errors = 0;
	int          cmp_count  = 0;
	int          cycles     = 0;

	igx_host_model host_u (.o_scl(scl), .o_sda(sda_h), .i_sda(sda));
	igx_expander dut_u (
		.i_ref_clk        (i_ref_clk),
		.i_rst_b          (i_rst_b),
		.i_scl            (scl),
		.i_sda            (sda),
		.o_sda            (sda_lo),
		.o_sda_oe_b       (sda_oe_b),
		.i_addr_sel       (i_addr_sel),
		.i_port_pin       (i_port_pin),
		.o_port_pin       (o_port_pin),
		.o_port_oe_b      (o_port_oe_b),
		.o_pull_enable    (o_pull_enable),
		.o_pull_up        (o_pull_up),
		.o_drive_strength (o_drive_strength),
		.o_int            (int_lo),
		.o_int_oe_b       (int_oe_b)
	);

	// Core clock, 50 ns period
	initial begin
		forever #25 i_ref_clk = ~i_ref_clk;
	end
	// Cuts a hang short
	always @(posedge i_ref_clk) begin
		cycles++;
		if (cycles > 95000) begin
			num_errors++;
			test_done();
		end
	end
	// Random byte from a shift register seeded at 12358
	function automatic logic [7:0] rnd();
		lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		return lfsr[7:0];
	endfunction
	function automatic logic [7:0] adr(input logic sel, input logic rd);
		return {1'b0, ADDR_FIXED, sel} << 1 | {7'h00, rd};
	endfunction
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_ref_clk);
	endtask
	// Pointer write, bus left open for a data byte or a repeated start
	task automatic ptr(input logic [7:0] c);
		host_u.start();
		host_u.xfer(adr(i_addr_sel, 1'b0), 1'b1, rv, ack);
		chk("addr ack", 16'h0000, 16'(ack));
		host_u.xfer(c, 1'b1, rv, ack);
	endtask
	task automatic wr(input logic [7:0] c, input logic [7:0] d);
		ptr(c);
		host_u.xfer(d, 1'b1, rv, ack);
		chk("data ack", 16'h0000, 16'(ack));
		host_u.stop();
	endtask
	task automatic rdcur(input logic [7:0] e);
		host_u.start();
		host_u.xfer(adr(i_addr_sel, 1'b1), 1'b1, rv, ack);
		host_u.xfer(8'hff, 1'b1, rv, ack);
		host_u.stop();
		chk("read data", 16'(e), 16'(rv));
	endtask
	task automatic rd(input logic [7:0] c, input logic [7:0] e);
		ptr(c);
		rdcur(e);
	endtask
	task automatic pins(input logic [7:0] x);
		@(posedge i_ref_clk);
		i_port_pin <= x;
		tick(6);
	endtask
	task automatic test_done();
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		tick(4);
		i_rst_b <= 1'b1;
		tick(6);
		chk("oe", 16'h00ff, 16'(o_port_oe_b));
		chk("pulls", 16'h00ff, {o_pull_enable, o_pull_up});
		chk("drive", 16'hffff, o_drive_strength);
		chk("int", 16'h0001, 16'(int_line_b));
		for (int i = 0; i < 12; i++) begin
			rd(CODE[i], DFLT[i]);
		end
		// Random register contents, read-only places written too
		for (int r = 0; r < 3; r++) begin
			for (int i = 0; i < 12; i++) begin
				v[i] = rnd();
				if (i == 11) begin
					v[i] = 8'(r[0]);
				end
				wr(CODE[i], v[i]);
			end
			v[0] = v[2];
			v[10] = 8'h00;
			for (int i = 11; i >= 0; i--) begin
				rd(CODE[i], v[i]);
			end
			rdcur(v[0]);
			chk("oe", 16'(v[3] | ({8{v[11][0]}} & v[1])), 16'(o_port_oe_b));
			chk("pull en", 16'(v[7] & ~(~v[3] & {8{v[11][0]}})), 16'(o_pull_enable));
			chk("pull up", 16'(v[8]), 16'(o_pull_up));
			chk("level", 16'(v[1]), 16'(o_port_pin));
			chk("drive", {v[5], v[4]}, o_drive_strength);
		end
		// Interrupt on change, live and latched
		wr(REG_DIR, 8'hff);
		wr(REG_HOLD, 8'h00);
		wr(REG_MASK, 8'h00);
		p = rnd();
		p = p | 8'h01;
		pins(p);
		rd(REG_INPUT, p ^ v[2]);
		wr(REG_INVERT, 8'h00);
		pins(8'h00);
		chk("int on", 16'h0000, 16'(int_line_b));
		rd(REG_SOURCE, p);
		pins(p);
		chk("int back", 16'h0001, 16'(int_line_b));
		wr(REG_HOLD, 8'hff);
		pins(8'h00);
		pins(p);
		chk("int held", 16'h0000, 16'(int_line_b));
		rd(REG_INPUT, 8'h00);
		pins(8'h00);
		rd(REG_INPUT, 8'h00);
		wr(REG_MASK, 8'hff);
		pins(p);
		chk("int masked", 16'h0001, 16'(int_line_b));
		rd(REG_SOURCE, 8'h00);
		// Both addresses, a foreign one refused, slow host on the second
		for (int s = 0; s < 2; s++) begin
			tick(1);
			i_addr_sel <= s[0];
			host_u.q = (s == 0) ? 207 : 371;
			tick(4);
			host_u.start();
			host_u.xfer(adr(~s[0], 1'b0), 1'b1, rv, ack);
			host_u.stop();
			chk("foreign ack", 16'h0001, 16'(ack));
			wr(REG_OUTPUT, 8'h5a ^ 8'(s));
			rd(REG_OUTPUT, 8'h5a ^ 8'(s));
		end
		// Reset in mid-run, pointer and registers back to defaults
		tick(1);
		i_rst_b <= 1'b0;
		tick(3);
		chk("out rst", 16'h00ff, 16'(o_port_pin));
		i_rst_b <= 1'b1;
		tick(6);
		rdcur(p);
		rd(REG_HOLD, 8'h00);
		rd(REG_MASK, 8'hff);
		test_done();
	end
endmodule
